// File: hdl/sfr_slave.sv
// Purpose: two-wire serial slave with a 32K x 8 byte array
// Assumes: bus pins asynchronous to core_clk, sampled and filtered
// Notes:   open-drain data, write protect, select pin match
// Function
// - array of 32768 bytes, reached only through the serial bus
// - each received data byte is written to the array at once
// - holds a read-only identification value of maker, density, revision
// - answer only when address select bits match the select pins
// - unconnected select pins read as zero; the slave has no pull of its own and relies on pull-downs outside
// - data line only pulled low or released, never driven high
// - shift out after clock fall, sample in on clock rise
// - write protect high leaves the array unchanged
// - unconnected write protect reads as low; the slave has no pull of its own and relies on a pull-down outside
// - works at 100 kHz, 400 kHz and up to 3.4 MHz
// - first byte: type 1010b, select bits, read/write flag
// - 15-bit address, top bit ignored, increments and wraps
// - reads continue while master acknowledges, end on no-ack
// - stop or new start aborts and readies a new command
`timescale 1ns/1ps
`default_nettype none
module sfr_slave
   import sfr_pkg::*;
#(
   parameter int unsigned DEPTH = SFR_DEPTH
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [2:0] device_select_pins,
   input  wire logic       write_protect,
   output logic [23:0]     id_value
);

   // ======================================================
   // storage
   // byte array
   logic [7:0] mem [DEPTH];

   // ======================================================
   // input synchronisers
   // pins pulled down outside; two-flop sampling
   sfr_bus_t   bus_s1_q, bus_s2_q;
   logic [2:0] sel_s1_q, sel_s2_q;
   logic       wp_s1_q, wp_s2_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_s1_q <= '1;
         bus_s2_q <= '1;
         sel_s1_q <= 3'h0;
         sel_s2_q <= 3'h0;
         wp_s1_q  <= 1'b0;
         wp_s2_q  <= 1'b0;
      end else begin
         bus_s1_q <= '{scl: scl_in, sda: sda_in};
         bus_s2_q <= bus_s1_q;
         sel_s1_q <= device_select_pins;
         sel_s2_q <= sel_s1_q;
         wp_s1_q  <= write_protect;
         wp_s2_q  <= wp_s1_q;
      end
   end

   // ======================================================
   // glitch filter: a level must hold for the filter count
   // filter ahead of edges
   // filter short enough for a 3.4 MHz clock
   logic [3:0] fcnt_scl_q, fcnt_scl_d, fcnt_sda_q, fcnt_sda_d;
   sfr_bus_t   filt_q, filt_d, prev_q, prev_d;

   function automatic logic [3:0] filt_next(input logic [3:0] cnt,
                                            input logic raw,
                                            input logic cur);
      if (raw == cur)
         filt_next = 4'h0;
      else if (cnt == SFR_FILT_MAX)
         filt_next = 4'h0;
      else
         filt_next = cnt + 4'h1;
   endfunction

   always_comb begin
      fcnt_scl_d = filt_next(fcnt_scl_q, bus_s2_q.scl, filt_q.scl);
      fcnt_sda_d = filt_next(fcnt_sda_q, bus_s2_q.sda, filt_q.sda);
      filt_d     = filt_q;
      if (bus_s2_q.scl != filt_q.scl && fcnt_scl_q == SFR_FILT_MAX)
         filt_d.scl = bus_s2_q.scl;
      if (bus_s2_q.sda != filt_q.sda && fcnt_sda_q == SFR_FILT_MAX)
         filt_d.sda = bus_s2_q.sda;
      prev_d     = filt_q;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fcnt_scl_q <= 4'h0;
         fcnt_sda_q <= 4'h0;
         filt_q     <= '1;
         prev_q     <= '1;
      end else begin
         fcnt_scl_q <= fcnt_scl_d;
         fcnt_sda_q <= fcnt_sda_d;
         filt_q     <= filt_d;
         prev_q     <= prev_d;
      end
   end

   // bus events from the filtered levels
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = filt_q.scl & ~prev_q.scl;
   assign scl_fall = ~filt_q.scl & prev_q.scl;
   assign start_ev = filt_q.scl & prev_q.scl & prev_q.sda & ~filt_q.sda;
   assign stop_ev  = filt_q.scl & prev_q.scl & ~prev_q.sda & filt_q.sda;

   // ======================================================
   // protocol engine
   sfr_state_t  st_q, st_d;
   logic [7:0]  sh_q, sh_d;         // shift register
   logic [3:0]  bit_q, bit_d;       // bits seen in this byte (0..8)
   logic        ack_q, ack_d;       // in acknowledge slot
   logic        sel_q, sel_d;       // device byte matched, this transfer is ours
   logic [14:0] addr_q, addr_d;
   logic [6:0]  ahi_q, ahi_d;
   logic        drv_low_q, drv_low_d;
   logic        oe_q, oe_d;
   logic        we;
   logic [14:0] we_addr;
   logic [7:0]  rd_byte;

   function automatic logic [14:0] addr_inc(input logic [14:0] a);
      if (a == SFR_ADDR_LAST)
         addr_inc = SFR_ADDR_FIRST;
      else
         addr_inc = a + 15'h1;
   endfunction

   assign rd_byte = mem[addr_q];

   always_comb begin
      st_d      = st_q;
      sh_d      = sh_q;
      bit_d     = bit_q;
      ack_d     = ack_q;
      sel_d     = sel_q;
      addr_d    = addr_q;
      ahi_d     = ahi_q;
      drv_low_d = drv_low_q;
      we        = 1'b0;
      we_addr   = addr_q;
      if (start_ev) begin
         st_d      = ST_DEV;
         bit_d     = 4'h0;
         ack_d     = 1'b0;
         sel_d     = 1'b0;
         drv_low_d = 1'b0;
      end else if (stop_ev) begin
         st_d      = ST_IDLE;
         bit_d     = 4'h0;
         ack_d     = 1'b0;
         sel_d     = 1'b0;
         drv_low_d = 1'b0;
      end else if (st_q != ST_IDLE) begin
         if (scl_rise) begin
            if (ack_q) begin
               // master acknowledge after a read byte
               // no-ack ends the read
               if (st_q == ST_RACK && filt_q.sda)
                  st_d = ST_IDLE;
            end else if (st_q != ST_RD && st_q != ST_RACK) begin
               sh_d  = {sh_q[6:0], filt_q.sda};
               bit_d = bit_q + 4'h1;
            end else begin
               bit_d = bit_q + 4'h1;
            end
         end
         if (scl_fall) begin
            if (ack_q) begin
               // leaving acknowledge slot
               ack_d     = 1'b0;
               bit_d     = 4'h0;
               drv_low_d = 1'b0;
               if (st_q == ST_RD || st_q == ST_RACK) begin
                  st_d      = ST_RD;
                  sh_d      = rd_byte;
                  drv_low_d = ~rd_byte[7];
               end
            end else if (bit_q == 4'h8) begin
               ack_d = 1'b1;
               unique case (st_q)
                  ST_DEV: begin
                     sel_d = (sh_q[SFR_TYPE_MSB:SFR_TYPE_LSB] == SFR_TYPE_ID)
                           && (sh_q[SFR_SEL_MSB:SFR_SEL_LSB] == sel_s2_q);
                     drv_low_d = sel_d;
                     if (!sel_d)
                        st_d = ST_IDLE;
                     else if (sh_q[SFR_RW_BIT])
                        st_d = ST_RACK;
                     else
                        st_d = ST_AHI;
                  end
                  ST_AHI: begin
                     ahi_d     = sh_q[6:0];
                     drv_low_d = 1'b1;
                     st_d      = ST_ALO;
                  end
                  ST_ALO: begin
                     addr_d    = {ahi_q, sh_q};
                     drv_low_d = 1'b1;
                     st_d      = ST_WR;
                  end
                  ST_WR: begin
                     // commit now unless protected
                     // only a transfer that was acked may store
                     we        = sel_q & ~wp_s2_q;
                     addr_d    = addr_inc(addr_q);
                     drv_low_d = 1'b1;
                  end
                  ST_RD: begin
                     addr_d    = addr_inc(addr_q);
                     drv_low_d = 1'b0;
                     st_d      = ST_RACK;
                  end
                  default: begin
                     st_d = ST_IDLE;
                  end
               endcase
            end else if (st_q == ST_RD) begin
               // shift out next data bit
               sh_d      = {sh_q[6:0], 1'b0};
               drv_low_d = ~sh_q[6];
            end
         end
      end
   end

   always_comb begin
      oe_d = drv_low_d;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q      <= ST_IDLE;
         sh_q      <= 8'h00;
         bit_q     <= 4'h0;
         ack_q     <= 1'b0;
         sel_q     <= 1'b0;
         addr_q    <= SFR_ADDR_FIRST;
         ahi_q     <= 7'h00;
         drv_low_q <= 1'b0;
         oe_q      <= 1'b0;
      end else begin
         st_q      <= st_d;
         sh_q      <= sh_d;
         bit_q     <= bit_d;
         ack_q     <= ack_d;
         sel_q     <= sel_d;
         addr_q    <= addr_d;
         ahi_q     <= ahi_d;
         drv_low_q <= drv_low_d;
         oe_q      <= oe_d;
      end
   end

   // array write port, no reset on storage
   always_ff @(posedge core_clk) begin
      if (we)
         mem[we_addr] <= sh_q;
   end

   // ======================================================
   // outputs
   // identification fields gathered in their carrier
   sfr_id_t id_c;
   assign id_c = '{maker: SFR_ID_MAKER, density: SFR_ID_DENSITY,
                   rev: SFR_ID_REV};

   // data output fixed low, enable pulls
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sda_out  <= 1'b0;
         sda_oe   <= 1'b0;
         id_value <= 24'h000000;
      end else begin
         sda_out  <= 1'b0;
         sda_oe   <= oe_q;
         id_value <= id_c;
      end
   end

endmodule
`default_nettype wire

// File: hdl/sfr_pkg.sv
// Purpose: shared constants and types for the serial memory slave
// Assumes: one core clock at 250 MHz
// Notes:   all field positions and timing counts live here
`default_nettype none
package sfr_pkg;
   // ======================================================
   // array geometry
   localparam int unsigned SFR_ADDR_W     = 15;
   localparam int unsigned SFR_DEPTH      = 32768;
   localparam logic [14:0] SFR_ADDR_LAST  = 15'h7fff;
   localparam logic [14:0] SFR_ADDR_FIRST = 15'h0000;
   // ======================================================
   // slave address byte layout
   localparam logic [3:0]  SFR_TYPE_ID    = 4'ha;
   localparam int unsigned SFR_TYPE_MSB   = 7;
   localparam int unsigned SFR_TYPE_LSB   = 4;
   localparam int unsigned SFR_SEL_MSB    = 3;
   localparam int unsigned SFR_SEL_LSB    = 1;
   localparam int unsigned SFR_RW_BIT     = 0;
   // ======================================================
   // identification value, arbitrary neutral codes
   localparam logic [11:0] SFR_ID_MAKER   = 12'h0a5;
   localparam logic [7:0]  SFR_ID_DENSITY = 8'h02;
   localparam logic [3:0]  SFR_ID_REV     = 4'h1;
   // ======================================================
   // timing: input glitch filter
   localparam int unsigned SFR_CLK_MHZ    = 250;
   localparam int unsigned SFR_FILT_NS    = 20;
   localparam int unsigned SFR_FILT_CYC   =
      (SFR_FILT_NS * SFR_CLK_MHZ + 999) / 1000;
   localparam logic [3:0]  SFR_FILT_MAX   = 4'(SFR_FILT_CYC);

   // ======================================================
   // carrier for the sampled bus pins
   typedef struct packed {
      logic scl;
      logic sda;
   } sfr_bus_t;

   typedef struct packed {
      logic [11:0] maker;
      logic [7:0]  density;
      logic [3:0]  rev;
   } sfr_id_t;

   // protocol states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DEV  = 7'b0000010,
      ST_AHI  = 7'b0000100,
      ST_ALO  = 7'b0001000,
      ST_WR   = 7'b0010000,
      ST_RD   = 7'b0100000,
      ST_RACK = 7'b1000000
   } sfr_state_t;
endpackage
`default_nettype wire

// File: test/sfr_slave_props.sv
// Purpose: port checks for the serial memory slave
// Assumes: bus clock far slower than core_clk
// Notes:   bound to the slave from the bench top
`timescale 1ns/1ps
`default_nettype none
module sfr_slave_props
   import sfr_pkg::*;
#(
   parameter int unsigned DEPTH = SFR_DEPTH
) (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic [2:0]  device_select_pins,
   input wire logic        write_protect,
   input wire logic [23:0] id_value
);
   // ======================================================
   // phase counters
   logic [5:0] lo_q, lo_d, hi_q, hi_d;
   // saturating count of core cycles in each clock phase
   always_comb begin
      lo_d = scl_in ? 6'h00 : lo_q + 6'(lo_q != 6'h3f);
      hi_d = scl_in ? hi_q + 6'(hi_q != 6'h3f) : 6'h00;
   end
   // register the counters
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lo_q <= 6'h00;
         hi_q <= 6'h00;
      end else begin
         lo_q <= lo_d;
         hi_q <= hi_d;
      end
   end
   // ======================================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_stop;
      scl_in && $rose(sda_in);
   endsequence
   sequence s_turn;
      !scl_in && lo_q inside {[5:15]};
   endsequence
   property p_drive_low;
      sda_oe |-> sda_out == 1'b0;
   endproperty
   property p_id;
      !$past(rst) |-> id_value == {SFR_ID_MAKER, SFR_ID_DENSITY, SFR_ID_REV};
   endproperty
   property p_oe_rise;
      $rose(sda_oe) |-> s_turn;
   endproperty
   property p_oe_fall;
      $fell(sda_oe) |-> s_turn;
   endproperty
   property p_oe_hold;
      hi_q != 6'h00 |-> $stable(sda_oe);
   endproperty
   property p_oe_min;
      $rose(sda_oe) |-> sda_oe [*8];
   endproperty
   property p_stop_quiet;
      s_stop |-> !sda_oe [*8];
   endproperty
   property p_idle_quiet;
      hi_q > 6'h20 |-> !sda_oe;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("data line driven high");
   a_id: assert property (p_id)
      else $error("identification value wrong");
   a_oe_rise: assert property (p_oe_rise)
      else $error("drive starts outside clock low phase");
   a_oe_fall: assert property (p_oe_fall)
      else $error("release outside clock low phase");
   a_oe_hold: assert property (p_oe_hold)
      else $error("drive changed while clock high");
   a_oe_min: assert property (p_oe_min)
      else $error("drive pulse too short");
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("drive after stop");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("drive on idle bus");
endmodule
`default_nettype wire

// File: test/sfr_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: 125 ns bit period, data moved mid low phase
// Notes:   data line only pulled low or released
`timescale 1ns/1ps
`default_nettype none
module sfr_master (
   output logic     scl,
   output logic     sda_pull,
   input wire logic sda
);
   localparam realtime Q = 31.25;
   // bus idle: clock high, data released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #(2 * Q);
   endtask
   // set in low phase, sample on rise
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = !b;
      #Q scl = 1'b1;
      r = sda;
      #(2 * Q) scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak,
                       output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ak, k);
   endtask
endmodule
`default_nettype wire

// File: test/test_serial_fram_i2c_slave.sv
// Purpose: self-checking bench for the serial memory slave
// Assumes: master model runs the link at 8 MHz
// Notes:   written bytes kept in an associative array
`timescale 1ns/1ps
`default_nettype none
module test_serial_fram_i2c_slave
   import sfr_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        scl, pull, sda_oe, sda_out;
   logic        wp = 1'b0;
   logic [2:0]  sel = 3'h0;
   logic [23:0] id;
   wire logic   sda_w;
   int          miscompares = 0;
   int          comparisons = 0;
   int          seed = 32'h1ac4;
   int          cur = 0;
   logic [7:0]  mem [int];
   // ======================================================
   // clock, wire and instances
   always #2 core_clk = !core_clk;
   // open-drain data line with pull-up
   assign sda_w = (sda_oe ? sda_out : 1'b1) & !pull;
   sfr_slave sfr_slave_i (.core_clk(core_clk), .rst(rst), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .device_select_pins(sel), .write_protect(wp), .id_value(id));
   sfr_master sfr_master_i (.scl(scl), .sda_pull(pull), .sda(sda_w));
   // ======================================================
   // checking and verdict
   // compare one acknowledge slot level
   task automatic check_ack(input logic e, input logic s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] ack expected %b seen %b", e, s);
      end
   endtask
   // compare one byte read back from the array
   task automatic check_byte(input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] data expected %h seen %h", e, s);
      end
   endtask
   // compare the identification word
   task automatic check_id(input logic [23:0] e, input logic [23:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] id expected %h seen %h", e, s);
      end
   endtask
   task automatic conclude();
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // address a device and load the current address
   task automatic set_addr(input logic [2:0] s, input logic [15:0] a);
      logic [7:0] q;
      logic       k;
      sfr_master_i.start();
      sfr_master_i.xfer({SFR_TYPE_ID, s, 1'b0}, 1'b1, q, k);
      check_ack(1'b0, k);
      sfr_master_i.xfer(a[15:8], 1'b1, q, k);
      check_ack(1'b0, k);
      sfr_master_i.xfer(a[7:0], 1'b1, q, k);
      check_ack(1'b0, k);
      cur = int'(a[14:0]);
   endtask
   // write n random bytes, model follows write protect
   task automatic wr(input int n);
      logic [7:0] d, q;
      logic       k;
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         sfr_master_i.xfer(d, 1'b1, q, k);
         check_ack(1'b0, k);
         if (!wp) mem[cur] = d;
         cur = (cur + 1) % 32768;
      end
      sfr_master_i.stop();
   endtask
   // read n bytes after a repeated start, no-ack on the last
   task automatic rd(input logic [2:0] s, input int n);
      logic [7:0] q;
      logic       k;
      sfr_master_i.start();
      sfr_master_i.xfer({SFR_TYPE_ID, s, 1'b1}, 1'b1, q, k);
      check_ack(1'b0, k);
      for (int i = 0; i < n; i++) begin
         sfr_master_i.xfer(8'hff, i == n - 1, q, k);
         check_byte(mem[cur], q);
         cur = (cur + 1) % 32768;
      end
      sfr_master_i.stop();
   endtask
   // main sequence
   initial begin
      logic [7:0] q;
      logic       k;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      // keep every link edge off the core clock edges
      #0.1;
      check_id({SFR_ID_MAKER, SFR_ID_DENSITY, SFR_ID_REV}, id);
      set_addr(3'h0, 16'hfffe);
      wr(3);
      set_addr(3'h0, 16'h7ffe);
      rd(3'h0, 3);
      // every select value, a foreign type and a wrong select
      for (int s = 0; s < 8; s++) begin
         @(posedge core_clk) sel <= 3'(s);
         repeat (4) @(posedge core_clk);
         #0.1;
         sfr_master_i.start();
         sfr_master_i.xfer({4'hb, 3'(s), 1'b0}, 1'b1, q, k);
         check_ack(1'b1, k);
         sfr_master_i.start();
         sfr_master_i.xfer({SFR_TYPE_ID, 3'(s) ^ 3'h5, 1'b0}, 1'b1, q, k);
         check_ack(1'b1, k);
         set_addr(3'(s), 16'(s * 8));
         wr(2);
      end
      @(posedge core_clk) wp <= 1'b1;
      #0.1;
      set_addr(3'h7, 16'h0038);
      wr(2);
      @(posedge core_clk) wp <= 1'b0;
      #0.1;
      set_addr(3'h7, 16'h0038);
      rd(3'h7, 2);
      conclude();
   end
   // watchdog, about twice the expected run
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule
bind sfr_slave sfr_slave_props #(.DEPTH(DEPTH)) sfr_slave_props_i (
   .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe),
   .device_select_pins(device_select_pins),
   .write_protect(write_protect), .id_value(id_value));
`default_nettype wire
